/* File: inc/opsr_pkg.sv */
// Constants and types for the OTP potentiometer serial readback block
// How it works
// - A read returns the wiper setting of the channel picked by the latest write-mode instruction byte.
// - A write carrying only address and instruction bytes still changes the readback channel.
// - After the wiper byte a read sends a validation byte carrying the two OTP status bits.
// - After address and instruction are acknowledged, every further data byte updates the wiper.
// - Readback bytes keep coming for as long as the controller keeps reading.
// - Two strap pins form part of the bus address so four devices can share one bus.
// - Status field encodes 00 ready, 10 fatal error, 11 programmed.
// - Instruction byte MSB selects the channel, low for channel one, high for channel two.
// - In read mode the wiper byte follows the address acknowledge directly.
package opsr_pkg;
    localparam logic [4:0] ADDR_FIXED = 5'h0B;
    localparam int ADDR_STRAP_LSB = 1;
    localparam int INSTR_CHAN_BIT = 7;
    localparam logic [7:0] WIPER_RESET = 8'h80;
    localparam logic [1:0] OTP_READY = 2'h0;
    localparam logic [1:0] OTP_FATAL = 2'h2;
    localparam logic [1:0] OTP_DONE = 2'h3;
    localparam int OTP_VALID_LSB = 6;
    localparam int OTP_PROG_MS = 400;

    typedef enum logic [2:0] {
        OPSR_IDLE = 3'h0,
        OPSR_ADDR = 3'h1,
        OPSR_ACK = 3'h3,
        OPSR_WRX = 3'h2,
        OPSR_RDX = 3'h6,
        OPSR_RACK = 3'h7,
        OPSR_SKIP = 3'h5
    } opsr_state_t;
endpackage

/* File: src/opsr_sync.sv */
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module opsr_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_q <= '0;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule

/* File: src/opsr_top.sv */
// Two-wire target interface with wiper readback and OTP status byte
`timescale 1ns/1ps
module opsr_top
    import opsr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    output logic o_sda,
    input wire logic i_addr_strap_low,
    input wire logic i_addr_strap_high,
    input wire logic i_otp_status_low_bit,
    input wire logic i_otp_status_high_bit,
    output logic [7:0] o_wiper_setting_ch1,
    output logic [7:0] o_wiper_setting_ch2,
    output logic o_channel_select_bit
);
    // ==========================================================
    // Reset release and link-side reset
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) rst_sync_r <= 2'h0;
        else rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // Start and stop are SDA edges while SCL is high; async flags catch them
    logic start_r, stop_r;
    always_ff @(negedge i_sda or negedge rst_n) begin
        if (!rst_n) start_r <= 1'b0;
        else if (i_scl) start_r <= ~start_r;
    end
    always_ff @(posedge i_sda or negedge rst_n) begin
        if (!rst_n) stop_r <= 1'b0;
        else if (i_scl) stop_r <= ~stop_r;
    end

    // ==========================================================
    // Link domain, clocked by SCL
    opsr_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic rd_mode_r, byte_idx_r, start_seen_r, instr_done_r;
    logic chan_r;
    logic [7:0] tx_r;
    logic sda_drive_r;
    logic wr_tgl_r;
    logic [7:0] wr_data_r;
    logic wr_chan_r;
    logic [7:0] rd_wiper_s;
    logic [1:0] otp_s;
    logic [1:0] strap_s;
    logic sda_s;
    logic start_pend;
    logic stop_pend;
    logic [7:0] byte_in;
    logic addr_match;
    logic [7:0] valid_byte;
    logic [7:0] sel_wiper;
    logic [7:0] wiper1_s, wiper2_s;
    logic [7:0] load_byte;

    // Stop toggle last seen on the link side
    logic stop_seen_r;
    assign start_pend = start_r != start_seen_r;
    assign stop_pend = stop_r != stop_seen_r;
    assign byte_in = {shift_r[6:0], i_sda};
    assign addr_match = byte_in[7:3] == ADDR_FIXED
        && byte_in[2:1] == strap_s;
    assign valid_byte = {otp_s, 6'h00};
    assign sel_wiper = chan_r ? wiper2_s : wiper1_s;
    assign load_byte = byte_idx_r ? valid_byte : rd_wiper_s;

    // Straps and status sampled on link clock; quasi-static pins
    opsr_sync #(.W(4)) u_sync_link (
        .i_clk(i_scl),
        .i_rst_n(rst_n),
        .i_d({i_addr_strap_high, i_addr_strap_low,
              i_otp_status_high_bit, i_otp_status_low_bit}),
        .o_q({strap_s, otp_s})
    );
    // Wipers move only after each written data byte, long before the next read
    opsr_sync #(.W(16)) u_sync_wiper (
        .i_clk(i_scl),
        .i_rst_n(rst_n),
        .i_d({o_wiper_setting_ch2, o_wiper_setting_ch1}),
        .o_q({wiper2_s, wiper1_s})
    );
    assign rd_wiper_s = sel_wiper;
    assign sda_s = i_sda;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            OPSR_IDLE: state_nxt = OPSR_IDLE;
            OPSR_ADDR: if (bit_cnt_r == 4'h7)
                state_nxt = addr_match ? OPSR_ACK : OPSR_SKIP;
            OPSR_ACK: state_nxt = rd_mode_r ? OPSR_RDX : OPSR_WRX;
            OPSR_WRX: if (bit_cnt_r == 4'h7) state_nxt = OPSR_ACK;
            OPSR_RDX: if (bit_cnt_r == 4'h7) state_nxt = OPSR_RACK;
            OPSR_RACK: state_nxt = sda_s ? OPSR_SKIP : OPSR_RDX;
            OPSR_SKIP: state_nxt = OPSR_SKIP;
            default: state_nxt = OPSR_IDLE;
        endcase
        if (start_pend) state_nxt = OPSR_ADDR;
        else if (stop_pend) state_nxt = OPSR_IDLE;
    end

    // Sample on SCL rising edge
    always_ff @(posedge i_scl or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= OPSR_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rd_mode_r <= 1'b0;
            byte_idx_r <= 1'b0;
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b0;
            instr_done_r <= 1'b0;
            chan_r <= 1'b0;
            wr_tgl_r <= 1'b0;
            wr_data_r <= 8'h00;
            wr_chan_r <= 1'b0;
        end else begin
            start_seen_r <= start_r;
            stop_seen_r <= stop_r;
            state_r <= state_nxt;
            shift_r <= byte_in;
            // The rise that sees the start already carries the first bit
            if (start_pend) begin
                bit_cnt_r <= 4'h1;
            end else if (state_r == OPSR_ACK || state_r == OPSR_RACK) begin
                bit_cnt_r <= 4'h0;
            end else if (bit_cnt_r != 4'h7) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else begin
                bit_cnt_r <= 4'h0;
            end
            if (start_pend) begin
                instr_done_r <= 1'b0;
                byte_idx_r <= 1'b0;
            end
            if (state_r == OPSR_ADDR && bit_cnt_r == 4'h7) begin
                rd_mode_r <= i_sda;
            end
            if (state_r == OPSR_WRX && bit_cnt_r == 4'h7 && !start_pend) begin
                if (!instr_done_r) begin
                    chan_r <= byte_in[INSTR_CHAN_BIT];
                    instr_done_r <= 1'b1;
                end else begin
                    wr_data_r <= byte_in;
                    wr_chan_r <= chan_r;
                    wr_tgl_r <= ~wr_tgl_r;
                end
            end
            if (state_r == OPSR_RDX && bit_cnt_r == 4'h7) begin
                byte_idx_r <= ~byte_idx_r;
            end
        end
    end

    // Drive SDA on SCL falling edge
    always_ff @(negedge i_scl or negedge rst_n) begin
        if (!rst_n) begin
            sda_drive_r <= 1'b0;
            tx_r <= 8'h00;
        end else begin
            sda_drive_r <= 1'b0;
            // ACK is entered only from an own address or a written byte
            if (state_r == OPSR_ACK) begin
                sda_drive_r <= 1'b1;
            end else if (state_r == OPSR_RDX && bit_cnt_r == 4'h0) begin
                tx_r <= {load_byte[6:0], 1'b0};
                sda_drive_r <= ~load_byte[7];
            end else if (state_r == OPSR_RDX) begin
                tx_r <= {tx_r[6:0], 1'b0};
                sda_drive_r <= ~tx_r[7];
            end
        end
    end
    assign o_sda_oe = sda_drive_r;
    assign o_sda = 1'b0;
    assign o_channel_select_bit = chan_r;

    // ==========================================================
    // Wiper registers on the reference clock; write event by toggle
    logic [1:0] tgl_s;
    logic tgl_seen_r;
    logic [7:0] wiper1_r, wiper2_r;
    opsr_sync #(.W(1)) u_sync_tgl (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_d(wr_tgl_r),
        .o_q(tgl_s[0])
    );
    assign tgl_s[1] = tgl_s[0] != tgl_seen_r;
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_seen_r <= 1'b0;
            wiper1_r <= WIPER_RESET;
            wiper2_r <= WIPER_RESET;
        end else begin
            tgl_seen_r <= tgl_s[0];
            if (tgl_s[1] && !wr_chan_r) wiper1_r <= wr_data_r;
            if (tgl_s[1] && wr_chan_r) wiper2_r <= wr_data_r;
        end
    end
    assign o_wiper_setting_ch1 = wiper1_r;
    assign o_wiper_setting_ch2 = wiper2_r;

    // ==========================================================
    // Checks
    AST_WR_CH1: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        tgl_s[1] && !wr_chan_r |=> wiper1_r == $past(wr_data_r))
        else $error("wiper 1 not updated");
    AST_WR_CH2: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        tgl_s[1] && wr_chan_r |=> wiper2_r == $past(wr_data_r))
        else $error("wiper 2 not updated");
    AST_NO_WR_HOLD: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        !tgl_s[1] |=> $stable(wiper1_r) && $stable(wiper2_r))
        else $error("wiper changed without write");
    AST_CHAN_SEL: assert property (@(posedge i_scl)
        disable iff (!rst_n)
        state_r == OPSR_WRX && bit_cnt_r == 4'h7 && !instr_done_r
        && !start_pend |=> chan_r == $past(shift_r[6]))
        else $error("channel not taken");
    AST_NACK_FOREIGN: assert property (@(posedge i_scl)
        disable iff (!rst_n)
        state_r == OPSR_ADDR && bit_cnt_r == 4'h7 && !addr_match
        && !start_pend && !stop_pend
        |=> state_r == OPSR_SKIP && !sda_drive_r)
        else $error("acked foreign address");
    AST_ACK_OWN: assert property (@(posedge i_scl)
        disable iff (!rst_n)
        state_r == OPSR_ADDR && bit_cnt_r == 4'h7 && addr_match
        && !start_pend && !stop_pend
        |=> state_r == OPSR_ACK && sda_drive_r)
        else $error("own address not acked");
    AST_READ_FIRST: assert property (@(posedge i_scl)
        disable iff (!rst_n)
        state_r == OPSR_ACK && rd_mode_r && !start_pend && !stop_pend
        |=> state_r == OPSR_RDX)
        else $error("read byte not immediate");
    AST_VALID_IDX: assert property (@(posedge i_scl)
        disable iff (!rst_n)
        state_r == OPSR_RDX && bit_cnt_r == 4'h7
        |=> byte_idx_r != $past(byte_idx_r))
        else $error("validation byte order lost");
    AST_READ_MORE: assert property (@(posedge i_scl)
        disable iff (!rst_n)
        state_r == OPSR_RACK && !sda_s && !start_pend && !stop_pend
        |=> state_r == OPSR_RDX)
        else $error("repeated read stopped");
endmodule

/* File: sim/opsr_ctrl_model.sv */
// Two-wire bus controller model driving SCL and pulling SDA low
`timescale 1ns/1ps
module opsr_ctrl_model (
    output logic o_scl,
    output logic o_sda_pull,
    input wire logic i_sda
);
    // SCL idles high between frames, SDA released to its pull-up
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic start_c();
        o_sda_pull = 1'b1;
        #80 o_scl = 1'b0;
        #40;
    endtask
    // One 160 ns bit, data changed only while SCL is low
    task automatic bit_x(input logic b, output logic s);
        o_sda_pull = ~b;
        #40 o_scl = 1'b1;
        #40 s = i_sda;
        #40 o_scl = 1'b0;
        #40;
    endtask
    // Eight bits MSB first, then the ninth bit driven with a
    task automatic byte_x(input logic [7:0] d, input logic a,
                          output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(a, ak);
    endtask
    task automatic stop_c();
        o_sda_pull = 1'b1;
        #40 o_scl = 1'b1;
        #40 o_sda_pull = 1'b0;
        #80;
    endtask
endmodule

/* File: sim/opsr_top_tb.sv */
// Self-checking bench for the serial readback block
`timescale 1ns/1ps
module opsr_top_tb
    import opsr_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sl = 1'b0;
    logic sh = 1'b0;
    logic e0 = 1'b0;
    logic e1 = 1'b0;
    logic scl, pull, sda, oe, sda_o, chan;
    logic [7:0] w1, w2, ew1;
    logic [1:0] codes [3] = '{OTP_READY, OTP_FATAL, OTP_DONE};
    int n_mismatch = 0;
    int n_checks = 0;

    always #50 ref_clk = ~ref_clk;
    // Open-drain wire with pull-up
    assign sda = ~(pull | (oe & ~sda_o));

    opsr_ctrl_model m (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));
    opsr_top dut (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_oe(oe), .o_sda(sda_o), .i_addr_strap_low(sl),
        .i_addr_strap_high(sh), .i_otp_status_low_bit(e0),
        .i_otp_status_high_bit(e1), .o_wiper_setting_ch1(w1),
        .o_wiper_setting_ch2(w2), .o_channel_select_bit(chan)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s exp %h got %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    function automatic logic [7:0] adr(input logic rw);
        return {ADDR_FIXED, sh, sl, rw};
    endfunction
    // Write frame: address, instruction, n data bytes, stop
    // Fuse bit stays clear in every instruction, so no OTP wait is owed
    task automatic wr(input logic [7:0] a, input logic [7:0] ins,
                      input int n, input logic [7:0] d0,
                      input logic [7:0] d1, input logic eak);
        logic [7:0] q;
        logic ak;
        m.start_c();
        m.byte_x(a, 1'b1, q, ak);
        chk("addr ack", {7'h00, eak}, {7'h00, ak});
        m.byte_x(ins, 1'b1, q, ak);
        chk("instr ack", {7'h00, eak}, {7'h00, ak});
        for (int i = 0; i < n; i++) begin
            m.byte_x(i == 0 ? d0 : d1, 1'b1, q, ak);
            chk("data ack", {7'h00, eak}, {7'h00, ak});
        end
        m.stop_c();
        repeat (4) @(posedge ref_clk);
    endtask
    // Read frame: n pairs of wiper and validation bytes, NACK at end
    task automatic rd(input int n, input logic [7:0] ew,
                      input logic [7:0] ev);
        logic [7:0] q;
        logic ak;
        m.start_c();
        m.byte_x(adr(1'b1), 1'b1, q, ak);
        chk("raddr ack", 8'h00, {7'h00, ak});
        for (int i = 0; i < n; i++) begin
            m.byte_x(8'hFF, 1'b0, q, ak);
            chk("rd wiper", ew, q);
            m.byte_x(8'hFF, i == n - 1, q, ak);
            chk("rd valid", ev, q);
        end
        m.stop_c();
        repeat (4) @(posedge ref_clk);
    endtask

    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("wiper1 rst", WIPER_RESET, w1);
        chk("wiper2 rst", WIPER_RESET, w2);
        chk("chan rst", 8'h00, {7'h00, chan});
        ew1 = WIPER_RESET;
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk);
            sl <= s[0];
            sh <= s[1];
            repeat (4) @(posedge ref_clk);
            wr(adr(1'b0) ^ 8'h02, 8'h00, 1, 8'hEE, 8'hEE, 1'b1);
            chk("wiper1 ignored", ew1, w1);
            ew1 = 8'(8'h10 + s);
            wr(adr(1'b0), 8'h00, 1, ew1, 8'h00, 1'b0);
            chk("wiper1 strap", ew1, w1);
        end
        wr(adr(1'b0), 8'h00, 2, 8'h3C, 8'hA5, 1'b0);
        chk("wiper1 repeat", 8'hA5, w1);
        wr(adr(1'b0), 8'h80, 1, 8'h5A, 8'h00, 1'b0);
        chk("wiper2", 8'h5A, w2);
        chk("wiper1 kept", 8'hA5, w1);
        chk("chan two", 8'h01, {7'h00, chan});
        wr(adr(1'b0), 8'h00, 0, 8'h00, 8'h00, 1'b0);
        chk("chan one", 8'h00, {7'h00, chan});
        rd(2, 8'hA5, {OTP_READY, 6'h00});
        foreach (codes[k]) begin
            @(posedge ref_clk);
            {e1, e0} <= codes[k];
            repeat (4) @(posedge ref_clk);
            rd(1, 8'hA5, {codes[k], 6'h00});
        end
        wr(adr(1'b0), 8'h80, 0, 8'h00, 8'h00, 1'b0);
        rd(1, 8'h5A, {OTP_DONE, 6'h00});
        summarize();
    end
endmodule
